/* File: dhsp_top.v */
// debug halt logic and serial debug packet link
`timescale 1ns/1ps
`default_nettype none
`include "dhsp_regs.vh"
//
// Overview of operation
// - halt priority: double fault, hardware breakpoint, halt opcode, breakpoint pin
// - fault during fault processing halts core, status port shows halted code
// - enabled hardware breakpoint sets pending halt taken at next sample point
// - halt opcode halts at once and shows halted status code
// - halt opcode privileged; user mode traps unless user halt permit set
// - breakpoint pin sets pending halt, sampled once per instruction
// - halt cause in config/status bits 27:24, highest priority wins
// - core waits sixteen cycles after reset release before reset processing
// - breakpoint pin in first eight cycles after reset halts the core
// - resume after reset halt jumps to pc if written, else reset processing
// - breakpoint pin while stopped moves to halted; resume after stop opcode unless pc written, else jumps to pc
// - link is full duplex, bits in and out on each clock step
// - serial clock sampled on core clock edge as enable; data in same edge
// - serial output updates only after an edge with serial clock enable
// - packet is 17 bits: flag bit 16, data bits 15 to 0
// - received flag bit is ignored
// - responses: data, complete, not ready, bus error, illegal command codes
// - serial output changes only while serial clock is high
module dhsp_top #(
    parameter RST_WAIT = `DHSP_RST_WAIT,
    parameter BREAKPOINT_REQUEST_PIN_WIN = `DHSP_RST_BREAKPOINT_REQUEST_PIN_WIN
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        system_reset_input_i,
    input  wire        breakpoint_request_pin_i,
    input  wire        double_fault_i,
    input  wire        hw_breakpoint_i,
    input  wire        halt_opcode_i,
    input  wire        user_mode_i,
    input  wire        stop_opcode_i,
    input  wire        wake_i,
    input  wire        insn_sample_i,
    input  wire        debug_serial_clock_i,
    input  wire        debug_serial_in_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg  [3:0]  processor_status_port_o,
    output reg         privilege_violation_o,
    output reg         reset_exception_start_o,
    output reg         resume_jump_pc_o,
    output reg         resume_after_stop_o,
    output reg         debug_serial_out_o,
    output reg         packet_rx_o
);

// ---------------------------------------------------------------
// input synchronisers
// ---------------------------------------------------------------
reg [1:0] sclk_s_q;
reg [1:0] sdi_s_q;
reg [1:0] breakpoint_request_pin_s_q;
reg [1:0] system_reset_input_s_q;
reg       sclk_prev_q;

always @(posedge clk_i) begin
    if (rst_i) begin
        sclk_s_q    <= 2'h0;
        sdi_s_q     <= 2'h0;
        breakpoint_request_pin_s_q    <= 2'h0;
        system_reset_input_s_q    <= 2'h3;
        sclk_prev_q <= 1'b0;
    end else begin
        sclk_s_q    <= {sclk_s_q[0], debug_serial_clock_i};
        sdi_s_q     <= {sdi_s_q[0], debug_serial_in_i};
        breakpoint_request_pin_s_q    <= {breakpoint_request_pin_s_q[0], breakpoint_request_pin_i};
        system_reset_input_s_q    <= {system_reset_input_s_q[0], system_reset_input_i};
        sclk_prev_q <= sclk_s_q[1];
    end
end

wire sclk_rise = sclk_s_q[1] & ~sclk_prev_q;
wire sclk_high = sclk_s_q[1];
wire breakpoint_request_pin      = breakpoint_request_pin_s_q[1];
wire core_rst  = system_reset_input_s_q[1];

// ---------------------------------------------------------------
// registers and state
// ---------------------------------------------------------------
localparam ST_RESET   = 3'h0;
localparam ST_RUN     = 3'h1;
localparam ST_STOPPED = 3'h2;
localparam ST_HALTED  = 3'h3;

reg [2:0]  state_q;
reg [3:0]  cause_q;
reg        pend_q;
reg [3:0]  pend_cause_q;
reg        uhe_q;
reg        hwbp_en_q;
reg        pc_written_q;
reg        rst_halt_q;
reg        stop_halt_q;
reg [7:0]  rst_cnt_q;
reg [16:0] tx_pkt_q;
reg [16:0] shift_q;
reg [4:0]  bit_cnt_q;
reg [15:0] rx_data_q;
reg        rx_new_q;

// highest priority cause of a set of simultaneous requests
function [3:0] prio_cause;
    input df;
    input hw;
    input op;
    input pin;
    begin
        if (df)
            prio_cause = `DHSP_CAUSE_DFAULT;
        else if (hw)
            prio_cause = `DHSP_CAUSE_HWBP;
        else if (op)
            prio_cause = `DHSP_CAUSE_OPCODE;
        else if (pin)
            prio_cause = `DHSP_CAUSE_PIN;
        else
            prio_cause = `DHSP_CAUSE_NONE;
    end
endfunction

wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
wire ctrl_wr  = wb_wr & (wb_adr_i == `DHSP_ADR_CTRL);
wire tx_wr    = wb_wr & (wb_adr_i == `DHSP_ADR_TXPKT);
wire rx_rd    = wb_req & ~wb_we_i & (wb_adr_i == `DHSP_ADR_RXPKT);
wire go_cmd   = ctrl_wr & wb_dat_i[`DHSP_CTRL_GO];
wire pc_wr    = ctrl_wr & wb_dat_i[`DHSP_CTRL_PCWR];

wire op_ok    = halt_opcode_i & (~user_mode_i | uhe_q);
wire op_trap  = halt_opcode_i & user_mode_i & ~uhe_q;
wire hw_req   = hw_breakpoint_i & hwbp_en_q;
// ranking of pending and immediate causes
wire [3:0] new_pend = prio_cause(1'b0, hw_req, 1'b0, breakpoint_request_pin);
wire [3:0] imm_cause = prio_cause(double_fault_i,
                                  hw_req | (pend_q && pend_cause_q == `DHSP_CAUSE_HWBP),
                                  op_ok,
                                  breakpoint_request_pin | (pend_q && pend_cause_q == `DHSP_CAUSE_PIN));
wire run_halt = double_fault_i | op_ok | (pend_q & insn_sample_i);
wire win_open = (rst_cnt_q < BREAKPOINT_REQUEST_PIN_WIN);

// ---------------------------------------------------------------
// halt control
// ---------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i || core_rst) begin
        state_q                 <= ST_RESET;
        cause_q                 <= `DHSP_CAUSE_NONE;
        pend_q                  <= 1'b0;
        pend_cause_q            <= `DHSP_CAUSE_NONE;
        pc_written_q            <= 1'b0;
        rst_halt_q              <= 1'b0;
        stop_halt_q             <= 1'b0;
        rst_cnt_q               <= 8'h00;
        processor_status_port_o <= `DHSP_PST_RUN;
        privilege_violation_o   <= 1'b0;
        reset_exception_start_o <= 1'b0;
        resume_jump_pc_o        <= 1'b0;
        resume_after_stop_o     <= 1'b0;
    end else begin
        privilege_violation_o   <= 1'b0;
        reset_exception_start_o <= 1'b0;
        resume_jump_pc_o        <= 1'b0;
        resume_after_stop_o     <= 1'b0;
        if (pc_wr && state_q == ST_HALTED)
            pc_written_q <= 1'b1;
        if (state_q != ST_HALTED && new_pend != `DHSP_CAUSE_NONE) begin
            pend_q <= 1'b1;
            if (!pend_q || new_pend < pend_cause_q)
                pend_cause_q <= new_pend;
        end
        case (state_q)
            ST_RESET: begin
                rst_cnt_q <= rst_cnt_q + 8'h01;
                if (breakpoint_request_pin && win_open) begin
                    state_q                 <= ST_HALTED;
                    rst_halt_q              <= 1'b1;
                    pend_q                  <= 1'b0;
                    cause_q                 <= `DHSP_CAUSE_PIN;
                    processor_status_port_o <= `DHSP_PST_HALTED;
                end else if (rst_cnt_q == RST_WAIT - 1) begin
                    state_q                 <= ST_RUN;
                    pend_q                  <= 1'b0;
                    reset_exception_start_o <= 1'b1;
                end
            end
            ST_RUN: begin
                privilege_violation_o <= op_trap;
                if (run_halt) begin
                    state_q                 <= ST_HALTED;
                    cause_q                 <= imm_cause;
                    pend_q                  <= 1'b0;
                    processor_status_port_o <= `DHSP_PST_HALTED;
                end else if (stop_opcode_i) begin
                    state_q                 <= ST_STOPPED;
                    processor_status_port_o <= `DHSP_PST_STOPPED;
                end
            end
            ST_STOPPED: begin
                if (breakpoint_request_pin) begin
                    state_q                 <= ST_HALTED;
                    stop_halt_q             <= 1'b1;
                    pend_q                  <= 1'b0;
                    cause_q                 <= `DHSP_CAUSE_PIN;
                    processor_status_port_o <= `DHSP_PST_HALTED;
                end else if (wake_i) begin
                    state_q                 <= ST_RUN;
                    processor_status_port_o <= `DHSP_PST_RUN;
                end
            end
            ST_HALTED: begin
                if (go_cmd) begin
                    state_q                 <= ST_RUN;
                    processor_status_port_o <= `DHSP_PST_RUN;
                    rst_halt_q              <= 1'b0;
                    stop_halt_q             <= 1'b0;
                    pc_written_q            <= 1'b0;
                    if (rst_halt_q) begin
                        resume_jump_pc_o        <= pc_written_q;
                        reset_exception_start_o <= ~pc_written_q;
                    end else begin
                        resume_jump_pc_o    <= pc_written_q;
                        resume_after_stop_o <= stop_halt_q & ~pc_written_q;
                    end
                end
            end
            default: begin
                state_q <= ST_RESET;
            end
        endcase
    end
end

// ---------------------------------------------------------------
// serial link
// ---------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        shift_q            <= 17'h00000;
        bit_cnt_q          <= 5'h00;
        rx_data_q          <= 16'h0000;
        rx_new_q           <= 1'b0;
        packet_rx_o        <= 1'b0;
        debug_serial_out_o <= 1'b0;
    end else begin
        packet_rx_o <= 1'b0;
        if (rx_rd)
            rx_new_q <= 1'b0;
        // serial clock as enable, data sampled same edge
        if (sclk_rise) begin
            if (bit_cnt_q == `DHSP_PKT_BITS - 1) begin
                bit_cnt_q   <= 5'h00;
                // drop flag, keep 16 data bits
                rx_data_q   <= {shift_q[14:0], sdi_s_q[1]};
                rx_new_q    <= 1'b1;
                packet_rx_o <= 1'b1;
                shift_q     <= tx_pkt_q;
            end else begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
                shift_q   <= {shift_q[15:0], sdi_s_q[1]};
            end
        end
        // output moves only while clock high, after enable edge
        if (sclk_prev_q && sclk_high && bit_cnt_q != 5'h00)
            debug_serial_out_o <= shift_q[16];
        else if (sclk_rise && bit_cnt_q == `DHSP_PKT_BITS - 1)
            debug_serial_out_o <= tx_pkt_q[16];
    end
end

// ---------------------------------------------------------------
// wishbone slave
// ---------------------------------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o  <= 1'b0;
        wb_dat_o  <= 32'h00000000;
        uhe_q     <= 1'b0;
        hwbp_en_q <= 1'b0;
        // default answer until software loads one
        tx_pkt_q  <= `DHSP_RSP_NOTREADY;
    end else begin
        wb_ack_o <= wb_req;
        if (ctrl_wr) begin
            uhe_q     <= wb_dat_i[`DHSP_CTRL_UHE];
            hwbp_en_q <= wb_dat_i[`DHSP_CTRL_HWBP_EN];
        end
        // response flag and code loaded by software
        if (tx_wr)
            tx_pkt_q <= wb_dat_i[16:0];
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `DHSP_ADR_CSR:
                    wb_dat_o <= {4'h0, cause_q, 18'h00000, uhe_q, rx_new_q,
                                 pc_written_q, rst_halt_q,
                                 state_q == ST_STOPPED, state_q == ST_HALTED};
                `DHSP_ADR_CTRL:
                    wb_dat_o <= {30'h0, hwbp_en_q, uhe_q};
                `DHSP_ADR_RXPKT:
                    wb_dat_o <= {16'h0000, rx_data_q};
                `DHSP_ADR_TXPKT:
                    wb_dat_o <= {15'h0000, tx_pkt_q};
                default:
                    wb_dat_o <= 32'h00000000;
            endcase
        end
    end
end

endmodule // dhsp_top
`default_nettype wire

/* File: dhsp_regs.vh */
// register map and constants of the debug halt and serial port block
`ifndef DHSP_REGS_VH
`define DHSP_REGS_VH

`define DHSP_ADR_CSR        4'h0
`define DHSP_ADR_CTRL       4'h4
`define DHSP_ADR_RXPKT      4'h8
`define DHSP_ADR_TXPKT      4'hC

`define DHSP_CSR_CAUSE_HI   27
`define DHSP_CSR_CAUSE_LO   24
`define DHSP_CSR_HALTED     0
`define DHSP_CSR_STOPPED    1
`define DHSP_CSR_RSTHALT    2
`define DHSP_CSR_PCWR       3
`define DHSP_CSR_RXNEW      4
`define DHSP_CSR_UHE        5

`define DHSP_CTRL_UHE       0
`define DHSP_CTRL_HWBP_EN   1
`define DHSP_CTRL_GO        2
`define DHSP_CTRL_PCWR      3

`define DHSP_CAUSE_NONE     4'h0
`define DHSP_CAUSE_DFAULT   4'h1
`define DHSP_CAUSE_HWBP     4'h2
`define DHSP_CAUSE_OPCODE   4'h3
`define DHSP_CAUSE_PIN      4'h4

`define DHSP_PST_RUN        4'h0
`define DHSP_PST_STOPPED    4'hE
`define DHSP_PST_HALTED     4'hF

`define DHSP_RST_WAIT       16
`define DHSP_RST_BREAKPOINT_REQUEST_PIN_WIN   8
`define DHSP_PKT_BITS       17

`define DHSP_RSP_CMDDONE    17'h0FFFF
`define DHSP_RSP_NOTREADY   17'h10000
`define DHSP_RSP_BUSERR     17'h10001
`define DHSP_RSP_ILLEGAL    17'h1FFFF

`endif

/* File: dhsp_assertions.sv */
// concurrent checks on the ports of the debug halt block
`timescale 1ns/1ps
`default_nettype none
module dhsp_checker (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       double_fault_i,
    input wire logic       halt_opcode_i,
    input wire logic       user_mode_i,
    input wire logic       stop_opcode_i,
    input wire logic       debug_serial_clock_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [3:0] processor_status_port_o,
    input wire logic       privilege_violation_o,
    input wire logic       debug_serial_out_o,
    input wire logic       packet_rx_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [3:0] processor_status_port = processor_status_port_o;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    pst_legal_a:
        assert property (processor_status_port == 4'h0 || processor_status_port == 4'hE || processor_status_port == 4'hF) else $error("bad status");
    df_halt_a:
        assert property (double_fault_i && processor_status_port == 4'h0 |=> processor_status_port == 4'hF) else $error("no halt");
    user_trap_a:
        assert property (halt_opcode_i && user_mode_i && processor_status_port == 4'h0
            |=> privilege_violation_o || processor_status_port == 4'hF) else $error("opcode ignored");
    trap_cause_a:
        assert property (privilege_violation_o |-> $past(halt_opcode_i) && $past(user_mode_i))
            else $error("stray trap");
    ack_once_a:
        assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    ack_due_a:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    sdo_high_a:
        assert property ($changed(debug_serial_out_o) && !$past(rst_i)
            |-> $past(debug_serial_clock_i) && $past(debug_serial_clock_i, 2))
            else $error("serial out moved while clock low");
    halt_holds_a:
        assert property (processor_status_port == 4'hF && !wb_cyc_i && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2)
            |=> processor_status_port == 4'hF) else $error("left halt without resume");
    stop_entry_a:
        assert property (stop_opcode_i && processor_status_port == 4'h0 |=> processor_status_port == 4'hE) else $error("no stop");
    halt_c: cover property (processor_status_port == 4'hF);
    trap_c: cover property (privilege_violation_o);
    pkt_c: cover property (packet_rx_o);
endmodule // dhsp_checker

bind dhsp_top dhsp_checker dhsp_checker_inst (.clk_i, .rst_i, .double_fault_i,
    .halt_opcode_i, .user_mode_i, .stop_opcode_i, .debug_serial_clock_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .processor_status_port_o, .privilege_violation_o,
    .debug_serial_out_o, .packet_rx_o);
`default_nettype wire

/* File: dhsp_host_model.sv */
// development system model: serial master of the debug link
`timescale 1ns/1ps
`default_nettype none
module dhsp_host_model (
    input  wire logic clk_i,
    output var  logic debug_serial_clock_o,
    output var  logic debug_serial_in_o,
    input  wire logic debug_serial_out_i
);
    // four core clocks low, four high: 160 ns period
    localparam int HALF = 4;
    initial begin
        debug_serial_clock_o = 1'b0;
        debug_serial_in_o = 1'b1;
    end
    task automatic xfer(input logic flag, input logic [15:0] dat, output logic [16:0] rx);
        logic [16:0] tx;
        tx = {flag, dat};
        @(posedge clk_i);
        for (int i = 16; i >= 0; i--) begin
            debug_serial_in_o <= tx[i];
            repeat (HALF) @(posedge clk_i);
            rx[i] = debug_serial_out_i;
            debug_serial_clock_o <= 1'b1;
            repeat (HALF) @(posedge clk_i);
            debug_serial_clock_o <= 1'b0;
        end
        @(posedge clk_i);
        debug_serial_in_o <= ~tx[0];
    endtask
endmodule // dhsp_host_model
`default_nettype wire

/* File: dhsp_top_test.sv */
// self-checking bench for the debug halt and serial block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got %0h want %0h", $time, g, e); end end
module dhsp_top_test;
    logic clk_i = 1'b0, rst_i = 1'b1, sys = 1'b0, breakpoint_request_pin = 1'b0, df = 1'b0, hw = 1'b0;
    logic op = 1'b0, um = 1'b0, stp = 1'b0, smp = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic wk = 1'b0;
    logic [3:0] adr = 4'h0, processor_status_port;
    logic [31:0] wdat = 32'h0, rdat, rd;
    logic [16:0] rx, prev;
    wire sclk, sdi, sdo, ack, pv, rxs, rjp, ras, prx;
    int n_errors, tests_run, n_pv, n_rxs, n_rjp, n_ras, n_prx, cnt, x0, j0;
    logic [16:0] codes [5] = '{17'h0FFFF, 17'h10001, 17'h1FFFF, 17'h01234, 17'h10000};
    always #10 clk_i = ~clk_i;
    dhsp_top dhsp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .system_reset_input_i(sys),
        .breakpoint_request_pin_i(breakpoint_request_pin), .double_fault_i(df), .hw_breakpoint_i(hw),
        .halt_opcode_i(op), .user_mode_i(um), .stop_opcode_i(stp), .wake_i(wk),
        .insn_sample_i(smp), .debug_serial_clock_i(sclk), .debug_serial_in_i(sdi),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .processor_status_port_o(processor_status_port),
        .privilege_violation_o(pv), .reset_exception_start_o(rxs), .resume_jump_pc_o(rjp),
        .resume_after_stop_o(ras), .debug_serial_out_o(sdo), .packet_rx_o(prx));
    dhsp_host_model dhsp_host_model_inst (.clk_i(clk_i), .debug_serial_clock_o(sclk),
        .debug_serial_in_o(sdi), .debug_serial_out_i(sdo));
    // ------------------------------------------------------------
    // pulse counters and timeout
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        n_pv <= n_pv + pv;
        n_rxs <= n_rxs + rxs;
        n_rjp <= n_rjp + rjp;
        n_ras <= n_ras + ras;
        n_prx <= n_prx + prx;
        cnt <= cnt + 1;
        if (cnt == 20000) begin
            n_errors++;
            results();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic core_reset();
        sys <= 1'b1;
        tick(4);
        sys <= 1'b0;
        x0 = n_rxs;
        j0 = n_rjp;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_wait();
        core_reset();
        tick(18);
        `CHK(n_rxs, x0)
        tick(12);
        `CHK(n_rxs, x0 + 1)
    endtask
    task automatic t_reset_halt(input logic pcw);
        core_reset();
        tick(3);
        breakpoint_request_pin <= 1'b1;
        tick(2);
        breakpoint_request_pin <= 1'b0;
        tick(30);
        `CHK(processor_status_port, 4'hF)
        wb(1'b0, 4'h0, 32'h0);
        `CHK({rd[27:24], rd[2]}, 5'h09)
        `CHK(n_rxs, x0)
        if (pcw) wb(1'b1, 4'h4, 32'h8);
        wb(1'b1, 4'h4, 32'h4);
        tick(25);
        `CHK(n_rjp, j0 + pcw)
        `CHK(n_rxs, x0 + !pcw)
    endtask
    task automatic t_prio();
        wb(1'b1, 4'h4, 32'h2);
        for (int c = 1; c <= 4; c++) begin
            @(posedge clk_i);
            df <= (c == 1); hw <= (c <= 2); op <= (c <= 3); breakpoint_request_pin <= 1'b1;
            @(posedge clk_i);
            df <= 1'b0; hw <= 1'b0; op <= 1'b0;
            tick(4);
            smp <= 1'b1; breakpoint_request_pin <= 1'b0;
            @(posedge clk_i);
            smp <= 1'b0;
            tick(3);
            `CHK(processor_status_port, 4'hF)
            wb(1'b0, 4'h0, 32'h0);
            `CHK(rd[27:24], c[3:0])
            wb(1'b1, 4'h4, 32'h6);
            tick(3);
        end
    endtask
    task automatic t_user(input logic [31:0] ctl, input logic [3:0] exp);
        wb(1'b1, 4'h4, ctl);
        x0 = n_pv;
        um <= 1'b1; op <= 1'b1;
        @(posedge clk_i);
        op <= 1'b0;
        tick(3);
        um <= 1'b0;
        `CHK(processor_status_port, exp)
        `CHK(n_pv, x0 + (exp == 4'h0))
        wb(1'b1, 4'h4, 32'h4);
        tick(3);
    endtask
    task automatic t_stop();
        x0 = n_ras;
        stp <= 1'b1;
        @(posedge clk_i);
        stp <= 1'b0;
        tick(3);
        `CHK(processor_status_port, 4'hE)
        breakpoint_request_pin <= 1'b1;
        tick(2);
        breakpoint_request_pin <= 1'b0;
        tick(8);
        `CHK(processor_status_port, 4'hF)
        wb(1'b1, 4'h4, 32'h4);
        tick(3);
        `CHK({processor_status_port, n_ras[3:0]}, {4'h0, x0[3:0] + 4'h1})
        stp <= 1'b1;
        @(posedge clk_i);
        stp <= 1'b0;
        wk <= 1'b1;
        @(posedge clk_i);
        wk <= 1'b0;
        tick(2);
        `CHK({processor_status_port, n_ras[3:0]}, {4'h0, x0[3:0] + 4'h1})
    endtask
    task automatic t_serial();
        dhsp_host_model_inst.xfer(1'b0, 16'h0000, rx);
        x0 = n_prx;
        dhsp_host_model_inst.xfer(1'b1, 16'hA5C3, rx);
        tick(8);
        `CHK(rx, 17'h10000)
        `CHK(n_prx, x0 + 1)
        wb(1'b0, 4'h0, 32'h0);
        `CHK(rd[4], 1'b1)
        wb(1'b0, 4'h8, 32'h0);
        `CHK(rd[15:0], 16'hA5C3)
        prev = 17'h10000;
        foreach (codes[i]) begin
            wb(1'b1, 4'hC, {15'h0, codes[i]});
            wb(1'b0, 4'hC, 32'h0);
            `CHK(rd[16:0], codes[i])
            dhsp_host_model_inst.xfer(1'b0, 16'h1234, rx);
            `CHK(rx, prev)
            dhsp_host_model_inst.xfer(1'b0, 16'h1234, rx);
            `CHK(rx, codes[i])
            prev = codes[i];
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        tick(6);
        rst_i <= 1'b0;
        tick(30);
        t_reset_wait();
        t_reset_halt(1'b0);
        t_reset_halt(1'b1);
        t_prio();
        t_user(32'h0, 4'h0);
        t_user(32'h1, 4'hF);
        t_stop();
        t_serial();
        results();
    end
endmodule // dhsp_top_test
`default_nettype wire
